/* hdl/dsm_regs.svh */
// constants for the ds3 to sts-1 payload envelope bit mapper
`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH

// row geometry: payload bits per row after the path overhead byte
`define DSM_ROW_BITS      10'h2B0
`define DSM_ROW_LAST_POS  10'h2AF
`define DSM_POS_ZERO      10'h000
`define DSM_POS_ONE       10'h001
`define DSM_ROW_ZERO      4'h0
`define DSM_ROW_ONE       4'h1
`define DSM_ROW_LAST      4'h8

// slot positions inside one row
`define DSM_FIXED_A_HI    10'h007
`define DSM_COMM_LO       10'h008
`define DSM_COMM_HI       10'h009
`define DSM_FIXED_B_HI    10'h00C
`define DSM_CTRL_FIRST    10'h00D
`define DSM_CTRL_STRIDE   10'h07D
`define DSM_CTRL_SPAN     10'h271
`define DSM_DATA_LAST     10'h27E
`define DSM_OPP_POS       10'h27F

// rows whose opportunity bit carries data in nominal mode
`define DSM_NOM_ROW_A     4'h2
`define DSM_NOM_ROW_B     4'h5
`define DSM_NOM_ROW_C     4'h8

// elastic bit store on the mapping side
`define DSM_STORE_DEPTH   7'h40
`define DSM_STORE_LAST    6'h3F
`define DSM_PTR_ZERO      7'h00
`define DSM_PTR_ONE       7'h01
`define DSM_FILL_THRESH   7'h20

// control bit vote
`define DSM_VOTE_ZERO     3'h0
`define DSM_VOTE_ONE      3'h1
`define DSM_VOTE_MAJ      3'h3
`define DSM_VOTE_ALL      3'h5

// envelope bit counters
`define DSM_CNT_ZERO      13'h0000
`define DSM_CNT_ONE       13'h0001

`endif

/* hdl/dsm_pkg.sv */
// types shared by the ds3 to sts-1 mapper files
`default_nettype none
package dsm_pkg;

	typedef enum logic [2:0]
	{
		DSM_FIXED,
		DSM_COMM,
		DSM_CTRL,
		DSM_DATA,
		DSM_OPP
	} dsm_slot_t;

endpackage

`default_nettype wire

/* hdl/dsm_slot_class.sv */
// classifies a payload bit position of a row into its slot kind
`timescale 1ns/100ps
`default_nettype none
`include "dsm_regs.svh"

module dsm_slot_class
(
	input  wire logic [9:0]        slot_pos,
	output var dsm_pkg::dsm_slot_t slot_kind,
	output logic                   slot_comm_idx
);

	//////////////////////////////////////////////////////////////////////
	// fixed ordering of slots within a row
	function automatic dsm_pkg::dsm_slot_t classify(input logic [9:0] pos);
		logic [9:0] rel;
		rel = pos - `DSM_CTRL_FIRST;
		if (pos <= `DSM_FIXED_A_HI)
			classify = dsm_pkg::DSM_FIXED;
		else if (pos <= `DSM_COMM_HI)
			classify = dsm_pkg::DSM_COMM;
		else if (pos <= `DSM_FIXED_B_HI)
			classify = dsm_pkg::DSM_FIXED;
		else if (pos <= `DSM_DATA_LAST)
		begin
			if ((rel % `DSM_CTRL_STRIDE) == `DSM_POS_ZERO &&
			    rel < `DSM_CTRL_SPAN)
				classify = dsm_pkg::DSM_CTRL;
			else
				classify = dsm_pkg::DSM_DATA;
		end
		else if (pos == `DSM_OPP_POS)
			classify = dsm_pkg::DSM_OPP;
		else
			classify = dsm_pkg::DSM_FIXED;
	endfunction

	//////////////////////////////////////////////////////////////////////
	// outputs
	assign slot_kind     = classify(slot_pos);
	assign slot_comm_idx = (slot_pos == `DSM_COMM_HI);

endmodule // dsm_slot_class

`default_nettype wire

/* hdl/dsm_ds3_sts1_mapper.sv */
// ds3 to sts-1 payload envelope bit mapper and demapper
// Notes on behaviour
// - every row holds 59 fixed filler bits
// - filler sent as zero, ignored on receive
// - 621 data bits per row, 5589 per envelope
// - framed ds3 overhead carried like any data
// - one opportunity bit per row, data or junk
// - five control bits per row flag opportunity
// - data opportunity: all control bits zero
// - junk opportunity: all control bits one
// - two communication bits per row, user exposed
// - row stuff decision from elastic store fill
// - envelope carries 5592 bits at nominal rate
// - nominal mode: rows 2,5,8 carry data
// - demapper emits data plus flagged opportunities
`timescale 1ns/100ps
`default_nettype none
`include "dsm_regs.svh"

module dsm_ds3_sts1_mapper
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              tx_ds3_data,
	input  wire logic              tx_ds3_valid,
	output logic                   tx_ds3_ready,
	input  wire logic              tx_nominal,
	input  wire logic [1:0]        tx_comm,
	input  wire logic              tx_spe_strobe,
	input  wire logic              tx_spe_first,
	output logic                   tx_spe_bit,
	output logic                   tx_spe_bit_valid,
	output logic                   tx_slip,
	output logic [12:0]            tx_envelope_bits,
	input  wire logic              rx_spe_strobe,
	input  wire logic              rx_spe_first,
	input  wire logic              rx_spe_bit,
	output logic                   rx_ds3_data,
	output logic                   rx_ds3_valid,
	output logic [1:0]             rx_comm,
	output logic                   rx_ctrl_err,
	output logic [12:0]            rx_envelope_bits
);

	//////////////////////////////////////////////////////////////////////
	// mapping side declarations
	logic [9:0]                    tx_pos;
	logic [3:0]                    tx_row;
	logic                          tx_opp_data;
	logic [6:0]                    tx_wr_ptr;
	logic [6:0]                    tx_rd_ptr;
	logic [12:0]                   tx_env_cnt;
	logic                          tx_store [0:`DSM_STORE_LAST];
	wire                           tx_first_now;
	wire  [9:0]                    tx_cur_pos;
	wire  [3:0]                    tx_cur_row;
	wire  [9:0]                    next_tx_pos;
	wire  [3:0]                    next_tx_row;
	wire                           tx_row_end;
	wire                           tx_env_end;
	wire                           tx_row_begin;
	dsm_pkg::dsm_slot_t            tx_kind;
	wire                           tx_comm_idx;
	wire  [6:0]                    tx_fill;
	wire                           tx_full;
	wire                           tx_empty;
	wire                           tx_wr;
	wire                           tx_take;
	wire                           tx_rd;
	wire                           tx_underflow;
	wire                           tx_nom_row;
	wire                           next_tx_opp_data;
	wire                           tx_store_bit;
	wire                           tx_payload_bit;
	wire                           next_tx_spe_bit;
	wire  [12:0]                   tx_cnt_base;
	wire  [12:0]                   next_tx_env_cnt;
	//////////////////////////////////////////////////////////////////////
	// mapping side position tracking
	assign tx_first_now = tx_spe_strobe & tx_spe_first;
	assign tx_cur_pos   = tx_first_now ? `DSM_POS_ZERO : tx_pos;
	assign tx_cur_row   = tx_first_now ? `DSM_ROW_ZERO : tx_row;
	assign tx_row_end   = (tx_cur_pos == `DSM_ROW_LAST_POS);
	assign tx_env_end   = tx_spe_strobe & tx_row_end &
	                      (tx_cur_row == `DSM_ROW_LAST);
	assign tx_row_begin = tx_spe_strobe & (tx_cur_pos == `DSM_POS_ZERO);
	assign next_tx_pos  = tx_row_end ? `DSM_POS_ZERO
	                                 : tx_cur_pos + `DSM_POS_ONE;
	assign next_tx_row  = !tx_row_end ? tx_cur_row
	                    : (tx_cur_row == `DSM_ROW_LAST) ? `DSM_ROW_ZERO
	                    : tx_cur_row + `DSM_ROW_ONE;
	dsm_slot_class u_tx_class
	(
		.slot_pos      (tx_cur_pos),
		.slot_kind     (tx_kind),
		.slot_comm_idx (tx_comm_idx)
	);
	//////////////////////////////////////////////////////////////////////
	// elastic bit store between ds3 source and envelope slots
	assign tx_fill      = tx_wr_ptr - tx_rd_ptr;
	assign tx_full      = (tx_fill == `DSM_STORE_DEPTH);
	assign tx_empty     = (tx_fill == `DSM_PTR_ZERO);
	assign tx_ds3_ready = ~tx_full;
	assign tx_wr        = tx_ds3_valid & ~tx_full;
	assign tx_take      = tx_spe_strobe &
	                      ((tx_kind == dsm_pkg::DSM_DATA) |
	                       ((tx_kind == dsm_pkg::DSM_OPP) &
	                        tx_opp_data));
	assign tx_rd        = tx_take & ~tx_empty;
	assign tx_underflow = tx_take & tx_empty;
	assign tx_store_bit = tx_store[tx_rd_ptr[5:0]];
	//////////////////////////////////////////////////////////////////////
	// per-row justification decision
	assign tx_nom_row = (tx_cur_row == `DSM_NOM_ROW_A) |
	                    (tx_cur_row == `DSM_NOM_ROW_B) |
	                    (tx_cur_row == `DSM_NOM_ROW_C);
	assign next_tx_opp_data = tx_nominal ? tx_nom_row
	                        : (tx_fill >= `DSM_FILL_THRESH);

	//////////////////////////////////////////////////////////////////////
	// outgoing slot selection
	assign tx_payload_bit  = tx_take & ~tx_empty & tx_store_bit;
	assign next_tx_spe_bit =
		(tx_kind == dsm_pkg::DSM_FIXED) ? 1'b0 :
		(tx_kind == dsm_pkg::DSM_COMM)  ? tx_comm[tx_comm_idx] :
		(tx_kind == dsm_pkg::DSM_CTRL)  ? ~tx_opp_data :
		tx_payload_bit;

	//////////////////////////////////////////////////////////////////////
	// envelope bit count
	assign tx_cnt_base     = tx_first_now ? `DSM_CNT_ZERO : tx_env_cnt;
	assign next_tx_env_cnt = tx_cnt_base +
	                         (tx_take ? `DSM_CNT_ONE : `DSM_CNT_ZERO);

	//////////////////////////////////////////////////////////////////////
	// mapping side registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_pos <= `DSM_POS_ZERO;
			tx_row <= `DSM_ROW_ZERO;
		end
		else if (tx_spe_strobe)
		begin
			tx_pos <= next_tx_pos;
			tx_row <= next_tx_row;
		end
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tx_opp_data <= 1'b0;
		else if (tx_row_begin)
			tx_opp_data <= next_tx_opp_data;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_wr_ptr <= `DSM_PTR_ZERO;
			tx_rd_ptr <= `DSM_PTR_ZERO;
		end
		else
		begin
			if (tx_wr)
				tx_wr_ptr <= tx_wr_ptr + `DSM_PTR_ONE;
			if (tx_rd)
				tx_rd_ptr <= tx_rd_ptr + `DSM_PTR_ONE;
		end
	end
	always_ff @(posedge clk)
	begin
		if (tx_wr)
			tx_store[tx_wr_ptr[5:0]] <= tx_ds3_data;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_spe_bit       <= 1'b0;
			tx_spe_bit_valid <= 1'b0;
			tx_slip          <= 1'b0;
		end
		else
		begin
			tx_spe_bit       <= tx_spe_strobe & next_tx_spe_bit;
			tx_spe_bit_valid <= tx_spe_strobe;
			tx_slip          <= tx_underflow;
		end
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_env_cnt       <= `DSM_CNT_ZERO;
			tx_envelope_bits <= `DSM_CNT_ZERO;
		end
		else if (tx_spe_strobe)
		begin
			tx_env_cnt <= tx_env_end ? `DSM_CNT_ZERO : next_tx_env_cnt;
			if (tx_env_end)
				tx_envelope_bits <= next_tx_env_cnt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// demapping side declarations
	logic [9:0]                    rx_pos;
	logic [3:0]                    rx_row;
	logic [2:0]                    rx_ones;
	logic [12:0]                   rx_env_cnt;
	wire                           rx_first_now;
	wire  [9:0]                    rx_cur_pos;
	wire  [3:0]                    rx_cur_row;
	wire  [9:0]                    next_rx_pos;
	wire  [3:0]                    next_rx_row;
	wire                           rx_row_end;
	wire                           rx_env_end;
	wire                           rx_row_begin;
	dsm_pkg::dsm_slot_t            rx_kind;
	wire                           rx_comm_idx;
	wire  [2:0]                    rx_ones_base;
	wire  [2:0]                    next_rx_ones;
	wire                           rx_is_opp;
	wire                           rx_opp_junk;
	wire                           rx_vote_split;
	wire                           rx_emit;
	wire  [12:0]                   rx_cnt_base;
	wire  [12:0]                   next_rx_env_cnt;
	//////////////////////////////////////////////////////////////////////
	// demapping side position tracking
	assign rx_first_now = rx_spe_strobe & rx_spe_first;
	assign rx_cur_pos   = rx_first_now ? `DSM_POS_ZERO : rx_pos;
	assign rx_cur_row   = rx_first_now ? `DSM_ROW_ZERO : rx_row;
	assign rx_row_end   = (rx_cur_pos == `DSM_ROW_LAST_POS);
	assign rx_env_end   = rx_spe_strobe & rx_row_end &
	                      (rx_cur_row == `DSM_ROW_LAST);
	assign rx_row_begin = rx_spe_strobe & (rx_cur_pos == `DSM_POS_ZERO);
	assign next_rx_pos  = rx_row_end ? `DSM_POS_ZERO
	                                 : rx_cur_pos + `DSM_POS_ONE;
	assign next_rx_row  = !rx_row_end ? rx_cur_row
	                    : (rx_cur_row == `DSM_ROW_LAST) ? `DSM_ROW_ZERO
	                    : rx_cur_row + `DSM_ROW_ONE;
	dsm_slot_class u_rx_class
	(
		.slot_pos      (rx_cur_pos),
		.slot_kind     (rx_kind),
		.slot_comm_idx (rx_comm_idx)
	);
	//////////////////////////////////////////////////////////////////////
	// control bit vote and extraction
	assign rx_ones_base  = rx_row_begin ? `DSM_VOTE_ZERO : rx_ones;
	assign next_rx_ones  = rx_ones_base +
	                       ((rx_spe_strobe & rx_spe_bit &
	                         (rx_kind == dsm_pkg::DSM_CTRL))
	                        ? `DSM_VOTE_ONE : `DSM_VOTE_ZERO);
	assign rx_is_opp     = rx_spe_strobe & (rx_kind == dsm_pkg::DSM_OPP);
	assign rx_opp_junk   = (rx_ones >= `DSM_VOTE_MAJ);
	assign rx_vote_split = (rx_ones != `DSM_VOTE_ZERO) &
	                       (rx_ones != `DSM_VOTE_ALL);
	assign rx_emit       = rx_spe_strobe &
	                       ((rx_kind == dsm_pkg::DSM_DATA) |
	                        ((rx_kind == dsm_pkg::DSM_OPP) &
	                         ~rx_opp_junk));
	assign rx_cnt_base     = rx_first_now ? `DSM_CNT_ZERO : rx_env_cnt;
	assign next_rx_env_cnt = rx_cnt_base +
	                         (rx_emit ? `DSM_CNT_ONE : `DSM_CNT_ZERO);

	//////////////////////////////////////////////////////////////////////
	// demapping side registers
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_pos <= `DSM_POS_ZERO;
			rx_row <= `DSM_ROW_ZERO;
		end
		else if (rx_spe_strobe)
		begin
			rx_pos <= next_rx_pos;
			rx_row <= next_rx_row;
		end
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rx_ones <= `DSM_VOTE_ZERO;
		else if (rx_spe_strobe)
			rx_ones <= next_rx_ones;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_ds3_data  <= 1'b0;
			rx_ds3_valid <= 1'b0;
			rx_ctrl_err  <= 1'b0;
		end
		else
		begin
			rx_ds3_valid <= rx_emit;
			rx_ctrl_err  <= rx_is_opp & rx_vote_split;
			if (rx_emit)
				rx_ds3_data <= rx_spe_bit;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rx_comm <= 2'h0;
		else if (rx_spe_strobe && rx_kind == dsm_pkg::DSM_COMM)
			rx_comm[rx_comm_idx] <= rx_spe_bit;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_env_cnt       <= `DSM_CNT_ZERO;
			rx_envelope_bits <= `DSM_CNT_ZERO;
		end
		else if (rx_spe_strobe)
		begin
			rx_env_cnt <= rx_env_end ? `DSM_CNT_ZERO : next_rx_env_cnt;
			if (rx_env_end)
				rx_envelope_bits <= next_rx_env_cnt;
		end
	end

endmodule // dsm_ds3_sts1_mapper

`default_nettype wire

/* bench/dsm_checker.sv */
// port assertions for the ds3 to sts-1 mapper
`timescale 1ns/100ps
`default_nettype none
module dsm_checker
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       tx_ds3_ready,
	input wire logic       tx_spe_strobe,
	input wire logic       tx_spe_first,
	input wire logic       tx_spe_bit,
	input wire logic       tx_spe_bit_valid,
	input wire logic       tx_slip,
	input wire logic       rx_spe_strobe,
	input wire logic       rx_ds3_valid,
	input wire logic [1:0] rx_comm,
	input wire logic       rx_ctrl_err
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////////////
	property p_ans;
		tx_spe_strobe |=> tx_spe_bit_valid;
	endproperty
	property p_idle;
		!tx_spe_strobe |=> !tx_spe_bit_valid && !tx_spe_bit;
	endproperty
	property p_first;
		tx_spe_strobe && tx_spe_first |=> !tx_spe_bit;
	endproperty
	property p_slip;
		tx_slip |-> tx_spe_bit_valid && !tx_spe_bit;
	endproperty
	property p_full;
		!tx_ds3_ready && !tx_spe_strobe |=> !tx_ds3_ready;
	endproperty
	property p_rxv;
		rx_ds3_valid |-> $past(rx_spe_strobe);
	endproperty
	property p_err;
		rx_ctrl_err |-> $past(rx_spe_strobe);
	endproperty
	property p_comm;
		!rx_spe_strobe |=> $stable(rx_comm);
	endproperty
	////////////////////////////////////////////////////////////////////////
	a_ans: assert property (p_ans) else $error("no bit answer");
	a_idle: assert property (p_idle) else $error("bit unasked");
	a_first: assert property (p_first) else $error("fill not 0");
	a_slip: assert property (p_slip) else $error("bad slip");
	a_full: assert property (p_full) else $error("full lost");
	a_rxv: assert property (p_rxv) else $error("stray bit");
	a_err: assert property (p_err) else $error("stray err");
	a_comm: assert property (p_comm) else $error("comm moved");
	c_slip: cover property (tx_slip);
	c_err: cover property (rx_ctrl_err);
	c_full: cover property (!tx_ds3_ready);
endmodule // dsm_checker
bind dsm_ds3_sts1_mapper dsm_checker dsm_checker_inst
(
	.clk, .arst_n, .tx_ds3_ready, .tx_spe_strobe, .tx_spe_first,
	.tx_spe_bit, .tx_spe_bit_valid, .tx_slip, .rx_spe_strobe,
	.rx_ds3_valid, .rx_comm, .rx_ctrl_err
);
`default_nettype wire

/* bench/dsm_framer_model.sv */
// framer model looping the mapped envelope back to the demapper
`timescale 1ns/100ps
`default_nettype none
module dsm_framer_model
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       stall,
	input  wire logic       flip_en,
	input  wire logic       tx_spe_bit,
	input  wire logic       tx_spe_bit_valid,
	output logic            tx_spe_strobe,
	output logic            tx_spe_first,
	output logic            rx_spe_strobe,
	output logic            rx_spe_first,
	output logic            rx_spe_bit,
	output logic            env_end,
	output logic [9:0]      pos_d,
	output logic [3:0]      row_d
);
	logic [9:0] pos;
	logic [3:0] row;
	logic       first_d;
	logic       tog;
	wire logic  at_end = pos == 10'h2AF;
	wire logic  flip = flip_en && pos_d == 10'h08A;
	assign tx_spe_strobe = arst_n && !stall;
	assign tx_spe_first = tx_spe_strobe && pos == 10'h000 && row == 4'h0;
	assign env_end = tx_spe_strobe && at_end && row == 4'h8;
	assign rx_spe_strobe = tx_spe_bit_valid;
	assign rx_spe_first = tx_spe_bit_valid && first_d;
	// one control bit is corrupted per row when asked; idle line toggles
	assign rx_spe_bit = tx_spe_bit_valid ? tx_spe_bit ^ flip : tog;
	////////////////////////////////////////////////////////////////////////
	// row and bit position in the fixed slot order
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pos <= 10'h000;
			row <= 4'h0;
			pos_d <= 10'h000;
			row_d <= 4'h0;
			first_d <= 1'b0;
			tog <= 1'b0;
		end
		else
		begin
			tog <= !tog;
			if (tx_spe_strobe)
			begin
				pos <= at_end ? 10'h000 : pos + 10'h001;
				row <= at_end ? (row == 4'h8 ? 4'h0 : row + 4'h1) : row;
				pos_d <= pos;
				row_d <= row;
				first_d <= tx_spe_first;
			end
		end
	end
endmodule // dsm_framer_model
`default_nettype wire

/* bench/tb_dsm_ds3_sts1_mapper.sv */
// self-checking bench for the ds3 to sts-1 mapper
`timescale 1ns/100ps
`default_nettype none
module tb_dsm_ds3_sts1_mapper;
	localparam logic [12:0] nom_bits = 13'h0009 * 13'h026D + 13'h0003;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       tx_ds3_data = 1'b0;
	logic       tx_ds3_valid = 1'b0;
	logic       tx_nominal = 1'b1;
	logic [1:0] tx_comm = 2'h2;
	logic       stall = 1'b0;
	logic       stl_en = 1'b0;
	logic       flip_en = 1'b0;
	logic       starve = 1'b0;
	logic       acc_v = 1'b0;
	logic       acc_b = 1'b0;
	logic       ctl_first = 1'b0;
	logic       q[$];
	int         err_count = 0;
	int         check_count = 0;
	int         cyc = 0;
	int         ctl_errs = 0;
	int         slips = 0;
	wire logic  tx_ds3_ready, tx_spe_strobe, tx_spe_first, tx_spe_bit;
	wire logic  tx_spe_bit_valid, tx_slip, rx_spe_strobe, rx_spe_first;
	wire logic  rx_spe_bit, rx_ds3_data, rx_ds3_valid, rx_ctrl_err, env_end;
	wire logic [12:0] tx_envelope_bits, rx_envelope_bits;
	wire logic [1:0]  rx_comm;
	wire logic [9:0]  pos_d;
	wire logic [3:0]  row_d;
	dsm_ds3_sts1_mapper dsm_ds3_sts1_mapper_inst
	(
		.clk, .arst_n, .tx_ds3_data, .tx_ds3_valid, .tx_ds3_ready,
		.tx_nominal, .tx_comm, .tx_spe_strobe, .tx_spe_first, .tx_spe_bit,
		.tx_spe_bit_valid, .tx_slip, .tx_envelope_bits, .rx_spe_strobe,
		.rx_spe_first, .rx_spe_bit, .rx_ds3_data, .rx_ds3_valid, .rx_comm,
		.rx_ctrl_err, .rx_envelope_bits
	);
	dsm_framer_model dsm_framer_model_inst
	(
		.clk, .arst_n, .stall, .flip_en, .tx_spe_bit, .tx_spe_bit_valid,
		.tx_spe_strobe, .tx_spe_first, .rx_spe_strobe, .rx_spe_first,
		.rx_spe_bit, .env_end, .pos_d, .row_d
	);
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [12:0] b13(input logic b);
		return {12'h000, b};
	endfunction
	function automatic dsm_pkg::dsm_slot_t kind(input logic [9:0] p);
		if (p == 10'h27F)
			return dsm_pkg::DSM_OPP;
		if (p == 10'h008 || p == 10'h009)
			return dsm_pkg::DSM_COMM;
		if (p >= 10'h00D && p <= 10'h201 && (p - 10'h00D) % 10'h07D == 10'h0)
			return dsm_pkg::DSM_CTRL;
		if (p >= 10'h00D && p <= 10'h27E)
			return dsm_pkg::DSM_DATA;
		return dsm_pkg::DSM_FIXED;
	endfunction
	task automatic check(input string what, input logic [12:0] seen,
		input logic [12:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tx_slot();
		dsm_pkg::dsm_slot_t k;
		k = kind(pos_d);
		if (pos_d == 10'h00D)
			ctl_first = tx_spe_bit;
		if (k == dsm_pkg::DSM_FIXED)
			check("fixed", b13(tx_spe_bit), 13'h0000);
		if (k == dsm_pkg::DSM_COMM)
			check("comm", b13(tx_spe_bit), b13(tx_comm[pos_d[0]]));
		if (k == dsm_pkg::DSM_CTRL)
			check("ctrl", b13(tx_spe_bit), b13(ctl_first));
		if (k == dsm_pkg::DSM_CTRL && tx_nominal)
			check("nom", b13(tx_spe_bit), b13(row_d % 4'h3 != 4'h2));
		if (k == dsm_pkg::DSM_OPP && ctl_first)
			check("junk", b13(tx_spe_bit), 13'h0000);
	endtask
	task automatic run(input string name, input int n, input logic nom,
		input logic stl, input logic flp, input logic stv, input logic chk);
		int c0;
		int s0;
		tx_nominal = nom;
		stl_en = stl;
		flip_en = flp;
		starve = stv;
		repeat (4) @(posedge clk);
		if (chk)
		begin
			check("tx env", tx_envelope_bits, nom_bits);
			check("rx env", rx_envelope_bits, nom_bits);
		end
		c0 = ctl_errs;
		s0 = slips;
		repeat (n) @(posedge clk iff env_end);
		#1;
		if (flp)
			check("errs", 13'(ctl_errs - c0), 13'h0009 * 13'(n));
		if (stv)
			check("slip", b13(slips > s0), 13'h0001);
		$display("test %s done", name);
	endtask
	////////////////////////////////////////////////////////////////////////
	// expected stream: slip zeros, then accepted bits, in store order
	always @(posedge clk)
	begin
		if (tx_slip)
		begin
			slips++;
			q.push_back(1'b0);
		end
		if (acc_v)
			q.push_back(acc_b);
		acc_v = arst_n && tx_ds3_valid && tx_ds3_ready;
		acc_b = tx_ds3_data;
		if (rx_ctrl_err)
			ctl_errs++;
		if (rx_ds3_valid && q.size() == 0)
			q.push_back(!rx_ds3_data);
		if (rx_ds3_valid)
			check("ds3", b13(rx_ds3_data), b13(q.pop_front()));
		if (tx_spe_bit_valid)
			tx_slot();
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 70000)
		begin
			err_count++;
			results();
		end
	end
	initial
	begin
		void'($urandom(97302));
		// stimulus thread draws from the seeded generator
		fork
			forever
			begin
				@(posedge clk);
				#1;
				stall = stl_en && $urandom_range(3) == 0;
				tx_ds3_valid = !starve && $urandom_range(15) != 0;
				tx_ds3_data = 1'($urandom_range(1));
			end
		join_none
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		run("nominal", 2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		run("stall flip", 1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
		run("fill", 2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		run("starve", 1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		run("recover", 1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		check("rx comm", {11'h000, rx_comm}, {11'h000, tx_comm});
		results();
	end
endmodule // tb_dsm_ds3_sts1_mapper
`default_nettype wire
